// ### rtl/sadc_ctrl.v
// control logic of a 10-bit successive-approximation converter
// assumes apb master on pclk; analog core strobes are pclk-synchronous,
// pin-level inputs (xclk_tick, wait_mode) come from other domains
//
// How it works
// - irq request at end of each conversion
// - with irq enabled, done flag low while requesting
// - runs in wait; irq usable as wakeup
// - control write aborts and restarts conversion
// - done flag read-only with irq off, continuous sets once
// - control write or result read clears flag
// - flag writable when irq enabled; reset clears
// - result read or control write drops irq
// - continuous repeats, else single; reset clears
// - five-bit field picks channel or reference
// - decode port b, port c, references
// - unused codes undefined, factory code reserved
// - all-ones code powers converter off
// - first conversion after power-up invalid
// - left format: high byte holds top eight
// - right format: high byte holds top two
// - high read freezes low until low read
// - two-bit format field, reset right justified
// - conversion takes 16 to 17 converter clocks
// - prescaler divides 1,2,4,8,16
// - selected pin ignores writes, reads zero
`timescale 1ns/1ps
`default_nettype none
`include "sadc_defs.vh"

module sadc_ctrl (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        xclk_tick,
   input  wire        wait_mode,
   input  wire [9:0]  core_result,
   input  wire        core_done,
   input  wire [9:0]  pin_in,
   output reg         core_start,
   output reg  [4:0]  core_channel,
   output reg         core_power_on,
   output reg         core_clk_en,
   output reg  [9:0]  pin_analog_sel,
   output reg  [9:0]  pin_out,
   output reg  [9:0]  pin_oe,
   output reg         irq_req,
   output reg         wake_req
);

   // ****************************************************************
   // state and registers
   // ****************************************************************
   localparam ST_IDLE = 3'b001;
   localparam ST_CONV = 3'b010;
   localparam ST_OFF  = 3'b100;

   reg  [2:0]  state_q;
   reg         done_q;
   reg         irq_en_q;
   reg         cont_q;
   reg  [4:0]  ch_q;
   reg  [2:0]  div_q;
   reg         clksel_q;
   reg  [1:0]  fmt_q;
   reg  [7:0]  high_q;
   reg  [7:0]  low_q;
   reg         frozen_q;
   reg         irq_q;
   reg         warmup_q;
   reg         first_q;
   reg  [3:0]  presc_q;
   reg  [4:0]  ccnt_q;
   reg         xs1_q;
   reg         xs2_q;
   reg         xs3_q;
   reg         ws1_q;
   reg         ws2_q;
   reg  [9:0]  ps1_q;
   reg  [9:0]  ps2_q;
   reg  [9:0]  port_out_q;
   reg  [9:0]  port_dir_q;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   wire        acc     = psel & penable & pready;
   wire        wr      = acc & pwrite;
   wire        rd      = acc & ~pwrite;
   wire        wr_sc   = wr & (paddr == `SADC_OFF_STATUS_CTRL);
   wire        wr_clk  = wr & (paddr == `SADC_OFF_CLOCK_CFG);
   wire        wr_pin  = wr & (paddr == `SADC_OFF_PIN_CTRL);
   wire        rd_high = rd & (paddr == `SADC_OFF_RESULT_HIGH);
   wire        rd_low  = rd & (paddr == `SADC_OFF_RESULT_LOW);
   wire        ch_off  = (ch_q == `SADC_CH_OFF);
   wire [4:0]  wch     = pwdata[`SADC_CH_MSB:`SADC_CH_LSB];
   // 8-bit truncation has no high/low interlock
   wire        interlock = (fmt_q != `SADC_FMT_TRUNC8);
   wire        mapped  = (paddr == `SADC_OFF_STATUS_CTRL) |
                         (paddr == `SADC_OFF_RESULT_HIGH) |
                         (paddr == `SADC_OFF_RESULT_LOW)  |
                         (paddr == `SADC_OFF_CLOCK_CFG)   |
                         (paddr == `SADC_OFF_PIN_CTRL);

   // ****************************************************************
   // converter clock: prescaled bus or synced external tick
   // ****************************************************************
   wire        xrise   = xs2_q & ~xs3_q;
   wire        src_tk  = clksel_q ? 1'b1 : xrise;
   reg  [3:0]  div_mask;
   always @* begin
      if (div_q[2]) begin
         div_mask = 4'hf;
      end else if (div_q == 3'h3) begin
         div_mask = 4'h7;
      end else if (div_q == 3'h2) begin
         div_mask = 4'h3;
      end else if (div_q == 3'h1) begin
         div_mask = 4'h1;
      end else begin
         div_mask = 4'h0;
      end
   end
   wire        adc_tk  = src_tk & ((presc_q & div_mask) == div_mask);

   // ****************************************************************
   // result formatting
   // ****************************************************************
   reg  [7:0]  fh;
   reg  [7:0]  fl;
   always @* begin
      fh = 8'h00;
      fl = 8'h00;
      case (fmt_q)
         `SADC_FMT_TRUNC8: begin
            fl = core_result[9:2];
         end
         `SADC_FMT_RIGHT: begin
            fh = {6'h00, core_result[9:8]};
            fl = core_result[7:0];
         end
         `SADC_FMT_LEFT: begin
            fh = core_result[9:2];
            fl = {core_result[1:0], 6'h00};
         end
         default: begin
            fh = {~core_result[9], core_result[8:2]};
            fl = {core_result[1:0], 6'h00};
         end
      endcase
   end

   // ****************************************************************
   // synchronisers and prescaler
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xs1_q   <= 1'b0;
         xs2_q   <= 1'b0;
         xs3_q   <= 1'b0;
         ws1_q   <= 1'b0;
         ws2_q   <= 1'b0;
         ps1_q   <= 10'h000;
         ps2_q   <= 10'h000;
         presc_q <= 4'h0;
      end else begin
         xs1_q   <= xclk_tick;
         xs2_q   <= xs1_q;
         xs3_q   <= xs2_q;
         ws1_q   <= wait_mode;
         ws2_q   <= ws1_q;
         ps1_q   <= pin_in;
         ps2_q   <= ps1_q;
         // restart divider on a control write: full first cycle
         if (wr_sc) begin
            presc_q <= 4'h0;
         end else if (src_tk) begin
            presc_q <= presc_q + 4'h1;
         end
      end
   end

   // ****************************************************************
   // conversion sequencer and registers
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q      <= ST_OFF;
         done_q       <= 1'b0;
         irq_en_q     <= 1'b0;
         cont_q       <= 1'b0;
         ch_q         <= `SADC_CH_RESET;
         div_q        <= `SADC_DIV_RESET;
         clksel_q     <= 1'b0;
         fmt_q        <= `SADC_FMT_RESET;
         high_q       <= 8'h00;
         low_q        <= 8'h00;
         frozen_q     <= 1'b0;
         irq_q        <= 1'b0;
         warmup_q     <= 1'b0;
         first_q      <= 1'b0;
         ccnt_q       <= 5'h00;
         core_start   <= 1'b0;
         port_out_q   <= 10'h000;
         port_dir_q   <= 10'h000;
      end else begin
         core_start <= 1'b0;
         if (wr_clk) begin
            div_q    <= pwdata[`SADC_DIV_MSB:`SADC_DIV_LSB];
            clksel_q <= pwdata[`SADC_BIT_CLKSEL];
            fmt_q    <= pwdata[`SADC_FMT_MSB:`SADC_FMT_LSB];
         end
         if (wr_pin) begin
            port_out_q <= pwdata[9:0];
            port_dir_q <= pwdata[25:16];
         end
         if (rd_high && interlock) begin
            frozen_q <= 1'b1;
         end
         if (rd_low) begin
            frozen_q <= 1'b0;
         end
         if (rd_high || rd_low) begin
            done_q <= 1'b0;
            irq_q  <= 1'b0;
         end
         if (wr_sc) begin
            irq_en_q <= pwdata[`SADC_BIT_IRQ_EN];
            cont_q   <= pwdata[`SADC_BIT_CONT];
            ch_q     <= wch;
            irq_q    <= 1'b0;
            first_q  <= 1'b1;
            ccnt_q   <= 5'h00;
            // writable flag only with irq enabled
            done_q   <= pwdata[`SADC_BIT_IRQ_EN] &
                        pwdata[`SADC_BIT_DONE];
            if (wch == `SADC_CH_OFF) begin
               state_q <= ST_OFF;
            end else begin
               if (ch_off) begin
                  warmup_q <= 1'b1;
               end
               state_q    <= ST_CONV;
               core_start <= 1'b1;
            end
         end else begin
            case (state_q)
               ST_CONV: begin
                  if (adc_tk && ccnt_q != `SADC_CONV_CYCLES) begin
                     ccnt_q <= ccnt_q + 5'h01;
                  end
                  if (core_done && ccnt_q == `SADC_CONV_CYCLES) begin
                     ccnt_q   <= 5'h00;
                     warmup_q <= 1'b0;
                     // warm-up pass must not use up the first-done slot
                     if (!warmup_q) begin
                        first_q <= 1'b0;
                        if (!frozen_q || !interlock) begin
                           high_q <= fh;
                           low_q  <= fl;
                        end
                        if (irq_en_q) begin
                           irq_q  <= 1'b1;
                           done_q <= 1'b0;
                        end else if (!cont_q || first_q) begin
                           done_q <= 1'b1;
                        end
                     end
                     if (cont_q || warmup_q) begin
                        core_start <= 1'b1;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // read mux and outputs
   // ****************************************************************
   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata         <= 32'h00000000;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         core_channel   <= `SADC_CH_RESET;
         core_power_on  <= 1'b0;
         core_clk_en    <= 1'b0;
         pin_analog_sel <= 10'h000;
         pin_out        <= 10'h000;
         pin_oe         <= 10'h000;
         irq_req        <= 1'b0;
         wake_req       <= 1'b0;
      end else begin
         // one wait state: answer in the second access cycle
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata  <= 32'h00000000;
         if (psel && penable && !pready && !pwrite) begin
            if (paddr == `SADC_OFF_STATUS_CTRL) begin
               prdata[7:0] <= {done_q, irq_en_q, cont_q, ch_q};
            end else if (paddr == `SADC_OFF_RESULT_HIGH) begin
               prdata[7:0] <= high_q;
            end else if (paddr == `SADC_OFF_RESULT_LOW) begin
               prdata[7:0] <= low_q;
            end else if (paddr == `SADC_OFF_CLOCK_CFG) begin
               prdata[7:0] <= {div_q, clksel_q, fmt_q, 2'h0};
            end else if (paddr == `SADC_OFF_PIN_CTRL) begin
               for (i = 0; i < 10; i = i + 1) begin
                  prdata[i] <= ps2_q[i] & ~pin_analog_sel[i];
               end
               prdata[25:16] <= port_dir_q;
            end
         end
         // factory and unused codes pass through; result undefined
         // new code and power go out with the start pulse, else the
         // core would see a start while still powered down
         core_channel  <= wr_sc ? wch : ch_q;
         core_power_on <= wr_sc ? (wch != `SADC_CH_OFF) : ~ch_off;
         core_clk_en   <= adc_tk & (state_q == ST_CONV);
         for (i = 0; i < 10; i = i + 1) begin
            pin_analog_sel[i] <= ~ch_off &&
                                 (ch_q <= `SADC_CH_LAST_EXT) &&
                                 (ch_q == i[4:0]);
         end
         pin_out  <= port_out_q & ~pin_analog_sel;
         pin_oe   <= port_dir_q & ~pin_analog_sel;
         irq_req  <= irq_q & irq_en_q;
         wake_req <= irq_q & irq_en_q & ws2_q;
      end
   end

endmodule
`default_nettype wire

// ### include/sadc_defs.vh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with word-aligned registers
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SADC_OFF_STATUS_CTRL  12'h000
`define SADC_OFF_RESULT_HIGH  12'h004
`define SADC_OFF_RESULT_LOW   12'h008
`define SADC_OFF_CLOCK_CFG    12'h00c
`define SADC_OFF_PIN_CTRL     12'h010

// ****************************************************************
// status/control fields
// ****************************************************************
`define SADC_BIT_DONE         7
`define SADC_BIT_IRQ_EN       6
`define SADC_BIT_CONT         5
`define SADC_CH_MSB           4
`define SADC_CH_LSB           0
`define SADC_CH_RESET         5'h1f
`define SADC_CH_OFF           5'h1f
`define SADC_CH_LAST_EXT      5'h09
`define SADC_CH_PORTC_FIRST   5'h08
`define SADC_CH_REF_HIGH      5'h1d
`define SADC_CH_REF_LOW       5'h1e
`define SADC_CH_FACTORY       5'h1b

// ****************************************************************
// clock config fields
// ****************************************************************
`define SADC_DIV_MSB          7
`define SADC_DIV_LSB          5
`define SADC_BIT_CLKSEL       4
`define SADC_FMT_MSB          3
`define SADC_FMT_LSB          2
`define SADC_DIV_RESET        3'h0
`define SADC_FMT_RESET        2'h1
`define SADC_FMT_TRUNC8       2'h0
`define SADC_FMT_RIGHT        2'h1
`define SADC_FMT_LEFT         2'h2
`define SADC_FMT_LEFT_SIGN    2'h3

// ****************************************************************
// timing
// ****************************************************************
`define SADC_CONV_CYCLES      5'h10
`define SADC_PRESC_W          4

`endif

// ### tb/sadc_core_model.sv
// behavioural analog core: counts converter clocks, returns a sample
// assumes start, clock enable and power come from sadc_ctrl on pclk
`timescale 1ns/1ps
`default_nettype none
module sadc_core_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       core_start,
   input  wire logic       core_clk_en,
   input  wire logic       core_power_on,
   input  wire logic [3:0] lag,
   input  wire logic [9:0] sample,
   output logic            core_done,
   output logic [9:0]      core_result
);
   // ****************
   // conversion
   // ****************
   logic       busy_q;
   logic [4:0] n_q;
   logic [3:0] w_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         n_q <= 5'h00;
         w_q <= 4'h0;
         core_done <= 1'b0;
         core_result <= 10'h000;
      end else begin
         core_done <= 1'b0;
         // idle bus churns so a stale capture shows
         core_result <= ~core_result;
         if (!core_power_on) begin
            busy_q <= 1'b0;
         end else if (core_start) begin
            busy_q <= 1'b1;
            n_q <= 5'h00;
            w_q <= lag;
         end else if (busy_q && n_q != 5'h10) begin
            n_q <= n_q + {4'h0, core_clk_en};
         end else if (busy_q && w_q != 4'h0) begin
            w_q <= w_q - 4'h1;
         end else if (busy_q) begin
            busy_q <= 1'b0;
            core_done <= 1'b1;
            core_result <= sample;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/sadc_ctrl_properties.sv
// port assertions for the converter control block
// assumes binding into sadc_ctrl, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module sadc_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        wait_mode,
   input wire logic        core_start,
   input wire logic        core_clk_en,
   input wire logic [4:0]  core_channel,
   input wire logic        core_power_on,
   input wire logic [9:0]  pin_analog_sel,
   input wire logic [9:0]  pin_oe,
   input wire logic        irq_req,
   input wire logic        wake_req
);
   // ****************
   // checks
   // ****************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_ctrl = psel & penable & pready & pwrite & (paddr == 12'h000);
   logic [5:0] tick_q;
   // ticks since the last start, saturating
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) tick_q <= 6'h00;
      else if (core_start) tick_q <= 6'h00;
      else if (core_clk_en && tick_q != 6'h3f) tick_q <= tick_q + 6'h01;
   end
   property p_start;
      wr_ctrl && pwdata[4:0] != 5'h1f |=> core_start;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_drop; wr_ctrl |-> ##2 !irq_req; endproperty
   a_drop: assert property (p_drop) else $error("irq held");
   property p_off;
      wr_ctrl ##2 1'b1 |-> core_channel == $past(pwdata[4:0], 2) &&
         core_power_on == (core_channel != 5'h1f);
   endproperty
   a_off: assert property (p_off) else $error("power state");
   property p_sel; $stable(core_channel) && core_channel < 5'h0a
      |-> pin_analog_sel == (10'h001 << core_channel); endproperty
   a_sel: assert property (p_sel) else $error("pin decode");
   property p_unsel; $stable(core_channel) && core_channel > 5'h09
      |-> pin_analog_sel == 10'h000; endproperty
   a_unsel: assert property (p_unsel) else $error("ref decode");
   property p_mask;
      $stable(pin_analog_sel) |-> (pin_analog_sel & pin_oe) == 10'h000;
   endproperty
   a_mask: assert property (p_mask) else $error("pin driven");
   property p_wake; (irq_req && wait_mode) [*4] |-> wake_req; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_ticks; $rose(irq_req) |-> $past(tick_q, 2) >= 6'h10;
   endproperty
   a_ticks: assert property (p_ticks) else $error("short conv");
endmodule
bind sadc_ctrl sadc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .pready, .paddr, .pwdata, .wait_mode, .core_start, .core_clk_en,
   .core_channel,
   .core_power_on, .pin_analog_sel, .pin_oe, .irq_req, .wake_req);
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench: apb master, core model, random samples
// assumes sadc_ctrl, the core model and the checker are compiled
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
   n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
   logic        penable = 1'b0, pwrite = 1'b0, xclk_tick = 1'b0;
   logic        wait_mode = 1'b0, pready, pslverr, core_done;
   logic        er;
   logic        core_start, core_power_on, core_clk_en, irq_req, wake_req;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [9:0]  pin_in = 10'h000, sample = 10'h000, a, core_result;
   logic [9:0]  pin_analog_sel, pin_out, pin_oe;
   logic [4:0]  core_channel, ch;
   logic [3:0]  lag = 4'h0;
   integer      seed = 16590, n_errors = 0, n_tests = 0, k, f, off = 1;
   always #5 pclk = ~pclk;
   always @(posedge pclk) xclk_tick <= ~xclk_tick;
   sadc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .xclk_tick, .wait_mode,
      .core_result, .core_done, .pin_in, .core_start, .core_channel,
      .core_power_on, .core_clk_en, .pin_analog_sel, .pin_out, .pin_oe,
      .irq_req, .wake_req);
   sadc_core_model u_core (.pclk, .presetn, .core_start, .core_clk_en,
      .core_power_on, .lag, .sample, .core_done, .core_result);
   // ****************
   // tasks
   // ****************
   task automatic bus(input logic w, input logic [11:0] ad,
                      input logic [31:0] d);
      integer n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rd = prdata;
      er = pslverr;
      if (n == 40) n_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic tick(input logic s);
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while ((s ? core_done !== 1'b1 : core_clk_en !== 1'b1) && k < 2000);
      if (k == 2000) n_errors++;
   endtask
   // leaving power-off costs one discarded conversion
   task automatic conv(input logic [7:0] c);
      integer nd;
      nd = off ? 2 : 1;
      off = (c[4:0] == 5'h1f);
      bus(1'b1, 12'h000, {24'h0, c});
      repeat (nd) tick(1'b1);
      repeat (3) @(posedge pclk);
   endtask
   function automatic logic [7:0] hi_exp(input logic [1:0] m,
                                         input logic [9:0] r);
      case (m)
         2'h1: hi_exp = {6'h00, r[9:8]};
         2'h2: hi_exp = r[9:2];
         default: hi_exp = {~r[9], r[8:2]};
      endcase
   endfunction
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      #400000;
      n_errors++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(1'b0, 12'h000, 32'h0);
      `CHK("ctrl reset", 8'h1f, rd[7:0])
      bus(1'b0, 12'h00c, 32'h0);
      `CHK("cfg reset", 8'h04, rd[7:0])
      `CHK("cfg err", 1'b0, er)
      bus(1'b0, 12'h014, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      $display("test reset done");
      for (f = 0; f < 4; f++) begin
         ch = 5'({$random(seed)} % 10);
         bus(1'b1, 12'h00c, {24'h0, 3'h0, f != 0, f[1:0], 2'h0});
         sample <= 10'($random(seed));
         conv({3'h0, ch});
         a = sample;
         bus(1'b0, 12'h000, 32'h0);
         `CHK("flag set", 1'b1, rd[7])
         `CHK("irq masked", 1'b0, irq_req)
         bus(1'b0, 12'h004, 32'h0);
         if (f != 0) `CHK("high", hi_exp(f[1:0], a), rd[7:0])
         bus(1'b0, 12'h008, 32'h0);
         `CHK("low", f > 1 ? {a[1:0], 6'h00} : f ? a[7:0] : a[9:2],
              rd[7:0])
         bus(1'b0, 12'h000, 32'h0);
         `CHK("flag clear", 1'b0, rd[7])
      end
      $display("test formats done");
      bus(1'b1, 12'h00c, 32'h14);
      sample <= 10'($random(seed));
      conv(8'h03);
      a = sample;
      bus(1'b0, 12'h004, 32'h0);
      sample <= ~a;
      conv(8'h03);
      bus(1'b0, 12'h008, 32'h0);
      `CHK("frozen low", a[7:0], rd[7:0])
      conv(8'h03);
      bus(1'b0, 12'h008, 32'h0);
      `CHK("fresh low", ~a[7:0], rd[7:0])
      $display("test interlock done");
      wait_mode <= 1'b1;
      lag <= 4'h3;
      bus(1'b1, 12'h000, 32'h45);
      k = 0;
      while (irq_req !== 1'b1 && k < 500) begin
         @(posedge pclk);
         k++;
      end
      `CHK("irq", 1'b1, irq_req)
      repeat (4) @(posedge pclk);
      `CHK("wake", 1'b1, wake_req)
      bus(1'b0, 12'h000, 32'h0);
      `CHK("flag under irq", 1'b0, rd[7])
      bus(1'b0, 12'h004, 32'h0);
      bus(1'b0, 12'h008, 32'h0);
      `CHK("irq drop", 1'b0, irq_req)
      bus(1'b1, 12'h000, 32'hc5);
      bus(1'b0, 12'h000, 32'h0);
      `CHK("flag write", 1'b1, rd[7])
      // converter is powered off mid-conversion before the processor leaves wait
      bus(1'b1, 12'h000, 32'h1f);
      off = 1;
      `CHK("power off", 1'b0, core_power_on)
      wait_mode <= 1'b0;
      $display("test interrupt done");
      sample <= 10'($random(seed));
      conv(8'h27);
      a = sample;
      bus(1'b0, 12'h000, 32'h0);
      `CHK("flag first", 1'b1, rd[7])
      bus(1'b0, 12'h004, 32'h0);
      bus(1'b0, 12'h008, 32'h0);
      sample <= ~a;
      tick(1'b1);
      repeat (3) @(posedge pclk);
      bus(1'b0, 12'h000, 32'h0);
      `CHK("flag once", 1'b0, rd[7])
      bus(1'b0, 12'h004, 32'h0);
      bus(1'b0, 12'h008, 32'h0);
      `CHK("repeat low", ~a[7:0], rd[7:0])
      $display("test continuous done");
      for (f = 0; f < 8; f++) begin
         bus(1'b1, 12'h00c, {24'h0, f[2:0], 5'h14});
         bus(1'b1, 12'h000, 32'h02);
         repeat (2) tick(1'b0);
         tick(1'b0);
         `CHK("divide", f[2] ? 16 : 1 << f, k)
      end
      $display("test prescaler done");
      pin_in <= 10'h3ff;
      bus(1'b1, 12'h010, 32'h03ff03ff);
      ch = 5'({$random(seed)} % 10);
      conv({3'h0, ch});
      bus(1'b0, 12'h010, 32'h0);
      `CHK("pin read", ~(10'h001 << ch), rd[9:0])
      `CHK("pin enable", ~(10'h001 << ch), pin_oe)
      `CHK("pin drive", ~(10'h001 << ch), pin_out)
      $display("test pins done");
      close_out();
   end
endmodule
`default_nettype wire
